// >>> rtl/dmt_top.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module dmt_top (
	// Clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst_b,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [dmt_pkg::APB_AW-1:0]   paddr,
	input  wire logic [dmt_pkg::APB_DW-1:0]   pwdata,
	output logic                              pready,
	output logic      [dmt_pkg::APB_DW-1:0]   prdata,
	output logic                              pslverr,
	// Processor bus watch
	input  wire logic                         bus_valid,
	input  wire logic [dmt_pkg::ADDR_W-1:0]   bus_addr,
	input  wire logic                         bus_read,
	input  wire logic                         bus_word,
	input  wire logic                         bus_fetch,
	// Instruction tagging
	output logic                              tag_attach,
	output logic      [dmt_pkg::CH_W-1:0]     tag_channel,
	input  wire logic                         cpu_taghit,
	input  wire logic [dmt_pkg::CH_W-1:0]     cpu_taghit_channel,
	// Breakpoint and interrupt
	output logic                              breakpoint_req,
	output logic                              irq
);

	// ****************************************
	// Declarations
	// ****************************************
	logic                                     arm_reg;
	logic                                     end_align_reg;
	dmt_pkg::dmt_seq_type                     state_reg;
	logic [dmt_pkg::STAT_W-1:0]               stat_reg;
	logic [dmt_pkg::STAT_W-1:0]               mask_reg;
	logic [dmt_pkg::STAT_W-1:0]               stat_set;
	logic [dmt_pkg::STAT_W-1:0]               stat_clr;
	logic [dmt_pkg::ADDR_W-1:0]               cmp_addr_reg [dmt_pkg::CH_N];
	logic [dmt_pkg::CC_W-1:0]                 cmp_ctrl_reg [dmt_pkg::CH_N];
	logic [dmt_pkg::NS_W*dmt_pkg::CH_N-1:0]   seq_reg      [dmt_pkg::SEQ_N];
	logic                                     s1_valid;
	logic [dmt_pkg::ADDR_W-1:0]               s1_addr;
	logic                                     s1_read;
	logic                                     s1_fetch;
	logic                                     s2_valid;
	logic                                     s2_read;
	logic                                     s2_fetch;
	logic [dmt_pkg::CH_N-1:0]                 raw_hit;
	logic [dmt_pkg::CH_N-1:0]                 forced_ev;
	logic [dmt_pkg::CH_N-1:0]                 tag_cand;
	logic [dmt_pkg::CH_N-1:0]                 tag_ev;
	logic [dmt_pkg::CH_N-1:0]                 match_ev;
	logic                                     win_valid;
	logic [dmt_pkg::CH_W-1:0]                 win_ch;
	dmt_pkg::dmt_seq_type                     win_next;
	logic                                     tag_any;
	logic [dmt_pkg::CH_W-1:0]                 tag_pick;
	logic                                     apb_wr;
	logic                                     apb_setup;
	logic                                     ctrl_wr;
	logic                                     immediate_trigger_bit_fire;
	logic                                     immediate_trigger_bit_end;
	logic                                     immediate_trigger_bit_begin;
	logic                                     final_entry;
	logic                                     final_end;
	logic                                     bkpt_next;
	logic                                     rd_hit;
	logic [dmt_pkg::APB_DW-1:0]               rd_data;
	logic [dmt_pkg::APB_DW-1:0]               prdata_reg;
	logic                                     tag_attach_reg;
	logic [dmt_pkg::CH_W-1:0]                 tag_channel_reg;
	logic                                     breakpoint_req_reg;

	dmt_cmp_if cmp_link [dmt_pkg::CH_N] ();

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic reg_hit(input logic [dmt_pkg::APB_AW-1:0] addr,
	                                 input logic [dmt_pkg::APB_AW-1:0] ofs);
		reg_hit = (addr == ofs);
	endfunction

	function automatic logic [dmt_pkg::APB_AW-1:0] cmp_ofs(input int ch, input logic ctl);
		logic [dmt_pkg::APB_AW-1:0] base;
		base = dmt_pkg::OFS_CMP_BASE + dmt_pkg::APB_AW'(ch) * dmt_pkg::OFS_CMP_STRIDE;
		cmp_ofs = ctl ? (base + dmt_pkg::OFS_CMP_CTRL) : base;
	endfunction

	function automatic logic [dmt_pkg::APB_AW-1:0] seq_ofs(input int st);
		seq_ofs = dmt_pkg::OFS_SEQ_BASE + dmt_pkg::APB_AW'(st) * dmt_pkg::OFS_SEQ_STRIDE;
	endfunction

	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign ctrl_wr   = apb_wr && reg_hit(paddr, dmt_pkg::OFS_CTRL);

	// ****************************************
	// APB answer
	// ****************************************
	// Zero wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !rd_hit;
	assign prdata  = prdata_reg;

	always_comb begin
		rd_data = '0;
		rd_hit  = 1'b0;
		if (reg_hit(paddr, dmt_pkg::OFS_CTRL)) begin
			rd_hit                    = 1'b1;
			rd_data[dmt_pkg::CTRL_ARM] = arm_reg;
			rd_data[dmt_pkg::CTRL_END] = end_align_reg;
			rd_data[dmt_pkg::CTRL_STATE_LSB +: dmt_pkg::NS_W] = state_reg;
		end
		if (reg_hit(paddr, dmt_pkg::OFS_STAT)) begin
			rd_hit                        = 1'b1;
			rd_data[dmt_pkg::STAT_W-1:0] = stat_reg;
		end
		if (reg_hit(paddr, dmt_pkg::OFS_MASK)) begin
			rd_hit                        = 1'b1;
			rd_data[dmt_pkg::STAT_W-1:0] = mask_reg;
		end
		for (int i = 0; i < dmt_pkg::CH_N; i++) begin
			if (reg_hit(paddr, cmp_ofs(i, 1'b0))) begin
				rd_hit                        = 1'b1;
				rd_data[dmt_pkg::ADDR_W-1:0] = cmp_addr_reg[i];
			end
			if (reg_hit(paddr, cmp_ofs(i, 1'b1))) begin
				rd_hit                      = 1'b1;
				rd_data[dmt_pkg::CC_W-1:0] = cmp_ctrl_reg[i];
			end
		end
		for (int s = 0; s < dmt_pkg::SEQ_N; s++) begin
			if (reg_hit(paddr, seq_ofs(s))) begin
				rd_hit                               = 1'b1;
				rd_data[dmt_pkg::NS_W*dmt_pkg::CH_N-1:0] = seq_reg[s];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= '0;
		end else if (apb_setup) begin
			prdata_reg <= pwrite ? '0 : rd_data;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			end_align_reg <= 1'b0;
		end else if (ctrl_wr) begin
			end_align_reg <= pwdata[dmt_pkg::CTRL_END];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= dmt_pkg::RST_STAT;
		end else if (apb_wr && reg_hit(paddr, dmt_pkg::OFS_MASK)) begin
			mask_reg <= pwdata[dmt_pkg::STAT_W-1:0];
		end
	end

	for (genvar g = 0; g < dmt_pkg::CH_N; g++) begin : gen_ch
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				cmp_addr_reg[g] <= dmt_pkg::ADDR_MIN;
			end else if (apb_wr && reg_hit(paddr, cmp_ofs(g, 1'b0))) begin
				cmp_addr_reg[g] <= pwdata[dmt_pkg::ADDR_W-1:0];
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				cmp_ctrl_reg[g] <= dmt_pkg::RST_CMP_CTRL;
			end else if (apb_wr && reg_hit(paddr, cmp_ofs(g, 1'b1))) begin
				cmp_ctrl_reg[g] <= pwdata[dmt_pkg::CC_W-1:0];
			end
		end

		assign cmp_link[g].bus_addr   = s1_addr;
		assign cmp_link[g].limit_addr = cmp_addr_reg[g];

		dmt_comparator u_cmp (
			.mclk  (mclk),
			.rst_b (rst_b),
			.link  (cmp_link[g])
		);

		// Outside mode turns the pair into two open-ended limits
		if (g < 2) begin : gen_pair
			assign raw_hit[g] = cmp_ctrl_reg[0][dmt_pkg::CC_OUT] ?
				((g == 0) ? cmp_link[g].hit_below : cmp_link[g].hit_above) :
				cmp_link[g].hit_eq;
		end else begin : gen_single
			assign raw_hit[g] = cmp_link[g].hit_eq;
		end

		// Forced path skips the read/write qualifiers on purpose
		assign forced_ev[g] = arm_reg && s2_valid && cmp_ctrl_reg[g][dmt_pkg::CC_EN] &&
			!cmp_ctrl_reg[g][dmt_pkg::CC_TAG] && raw_hit[g];
		assign tag_cand[g] = arm_reg && s2_valid && s2_fetch &&
			cmp_ctrl_reg[g][dmt_pkg::CC_EN] && cmp_ctrl_reg[g][dmt_pkg::CC_TAG] && raw_hit[g] &&
			(!cmp_ctrl_reg[g][dmt_pkg::CC_RWE] ||
			 (cmp_ctrl_reg[g][dmt_pkg::CC_RW] == s2_read));
		assign tag_ev[g] = arm_reg && cpu_taghit && cmp_ctrl_reg[g][dmt_pkg::CC_TAG] &&
			(cpu_taghit_channel == dmt_pkg::CH_W'(g));
	end

	for (genvar s = 0; s < dmt_pkg::SEQ_N; s++) begin : gen_seq
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				seq_reg[s] <= dmt_pkg::RST_SEQ;
			end else if (apb_wr && reg_hit(paddr, seq_ofs(s))) begin
				seq_reg[s] <= pwdata[dmt_pkg::NS_W*dmt_pkg::CH_N-1:0];
			end
		end
	end

	// ****************************************
	// Bus watch pipeline
	// ****************************************
	// A straddling word is judged by its aligned address alone
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_valid <= 1'b0;
			s1_addr  <= dmt_pkg::ADDR_MIN;
			s1_read  <= 1'b0;
			s1_fetch <= 1'b0;
		end else begin
			s1_valid <= bus_valid;
			s1_addr  <= bus_word ? {bus_addr[dmt_pkg::ADDR_W-1:1], 1'b0} : bus_addr;
			s1_read  <= bus_read;
			s1_fetch <= bus_fetch;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s2_valid <= 1'b0;
			s2_read  <= 1'b0;
			s2_fetch <= 1'b0;
		end else begin
			s2_valid <= s1_valid;
			s2_read  <= s1_read;
			s2_fetch <= s1_fetch;
		end
	end

	// ****************************************
	// Tag attach
	// ****************************************
	always_comb begin
		tag_any  = |tag_cand;
		tag_pick = '0;
		for (int i = dmt_pkg::CH_N - 1; i >= 0; i--) begin
			if (tag_cand[i]) begin
				tag_pick = dmt_pkg::CH_W'(i);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tag_attach_reg  <= 1'b0;
			tag_channel_reg <= '0;
		end else begin
			tag_attach_reg  <= tag_any;
			tag_channel_reg <= tag_pick;
		end
	end

	assign tag_attach  = tag_attach_reg;
	assign tag_channel = tag_channel_reg;

	// ****************************************
	// Match priority
	// ****************************************
	assign match_ev = forced_ev | tag_ev;

	always_comb begin
		win_valid = (|match_ev) && (state_reg != dmt_pkg::dmt_seq_final);
		win_ch    = '0;
		for (int i = dmt_pkg::CH_N - 1; i >= 0; i--) begin
			if (match_ev[i]) begin
				win_ch = dmt_pkg::CH_W'(i);
			end
		end
		for (int i = dmt_pkg::CH_N - 1; i >= 0; i--) begin
			if (match_ev[i] && (seq_reg[state_reg][i*dmt_pkg::NS_W +: dmt_pkg::NS_W] ==
			                    dmt_pkg::NS_W'(dmt_pkg::dmt_seq_final))) begin
				win_ch = dmt_pkg::CH_W'(i);
			end
		end
		win_next = dmt_pkg::dmt_seq_type'(seq_reg[state_reg][win_ch*dmt_pkg::NS_W +: dmt_pkg::NS_W]);
	end

	// ****************************************
	// Sequencer and arming
	// ****************************************
	assign immediate_trigger_bit_fire   = ctrl_wr && pwdata[dmt_pkg::CTRL_IMMEDIATE_TRIGGER_BIT] &&
		(pwdata[dmt_pkg::CTRL_ARM] || arm_reg);
	assign immediate_trigger_bit_end    = immediate_trigger_bit_fire && pwdata[dmt_pkg::CTRL_END];
	assign immediate_trigger_bit_begin  = immediate_trigger_bit_fire && !pwdata[dmt_pkg::CTRL_END];
	assign final_entry = arm_reg && win_valid && (win_next == dmt_pkg::dmt_seq_final) && !ctrl_wr;
	assign final_end   = final_entry && end_align_reg;
	assign bkpt_next   = immediate_trigger_bit_end || final_end;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			arm_reg <= 1'b0;
		end else if (ctrl_wr) begin
			// A begin-aligned trigger keeps the session armed so final state holds
			arm_reg <= immediate_trigger_bit_end ? 1'b0 : (pwdata[dmt_pkg::CTRL_ARM] || immediate_trigger_bit_begin);
		end else if (final_end) begin
			arm_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= dmt_pkg::dmt_seq_state1;
		end else if (immediate_trigger_bit_begin) begin
			state_reg <= dmt_pkg::dmt_seq_final;
		end else if (immediate_trigger_bit_end) begin
			state_reg <= dmt_pkg::dmt_seq_state1;
		end else if (ctrl_wr && !pwdata[dmt_pkg::CTRL_ARM]) begin
			state_reg <= dmt_pkg::dmt_seq_state1;
		end else if (!arm_reg) begin
			state_reg <= dmt_pkg::dmt_seq_state1;
		end else if (win_valid && !ctrl_wr) begin
			state_reg <= win_next;
		end
	end

	// ****************************************
	// Breakpoint request
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			breakpoint_req_reg <= 1'b0;
		end else begin
			breakpoint_req_reg <= bkpt_next;
		end
	end

	assign breakpoint_req = breakpoint_req_reg;

	// ****************************************
	// Status flags and interrupt
	// ****************************************
	// Hardware set beats a software clear in the same cycle
	always_comb begin
		stat_set = '0;
		if (arm_reg && win_valid && !ctrl_wr) begin
			stat_set[win_ch] = 1'b1;
		end
		stat_set[dmt_pkg::STAT_FINAL] = final_entry || immediate_trigger_bit_begin;
		stat_set[dmt_pkg::STAT_BKPT]  = bkpt_next;
		stat_clr = '0;
		if (apb_wr && reg_hit(paddr, dmt_pkg::OFS_STAT)) begin
			stat_clr = pwdata[dmt_pkg::STAT_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stat_reg <= dmt_pkg::RST_STAT;
		end else begin
			stat_reg <= (stat_reg & ~stat_clr) | stat_set;
		end
	end

	assign irq = |(stat_reg & mask_reg);

endmodule

// >>> rtl/dmt_pkg.sv
package dmt_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W  = 18;
	localparam int CH_N    = 3;
	localparam int CH_W    = 2;
	localparam int APB_AW  = 8;
	localparam int APB_DW  = 32;
	localparam int NS_W    = 2;
	localparam int STAT_W  = 5;
	localparam int CC_W    = 5;
	localparam int SEQ_N   = 3;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [APB_AW-1:0] OFS_CTRL       = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STAT       = 8'h04;
	localparam logic [APB_AW-1:0] OFS_MASK       = 8'h08;
	localparam logic [APB_AW-1:0] OFS_CMP_BASE   = 8'h10;
	localparam logic [APB_AW-1:0] OFS_CMP_STRIDE = 8'h08;
	localparam logic [APB_AW-1:0] OFS_CMP_CTRL   = 8'h04;
	localparam logic [APB_AW-1:0] OFS_SEQ_BASE   = 8'h40;
	localparam logic [APB_AW-1:0] OFS_SEQ_STRIDE = 8'h04;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_ARM       = 0;
	localparam int CTRL_IMMEDIATE_TRIGGER_BIT      = 1;
	localparam int CTRL_END       = 2;
	localparam int CTRL_STATE_LSB = 8;
	localparam int STAT_FINAL     = 3;
	localparam int STAT_BKPT      = 4;
	localparam int CC_EN          = 0;
	localparam int CC_TAG         = 1;
	localparam int CC_RWE         = 2;
	localparam int CC_RW          = 3;
	localparam int CC_OUT         = 4;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [ADDR_W-1:0]      ADDR_MIN     = 18'h00000;
	localparam logic [ADDR_W-1:0]      ADDR_MAX     = 18'h3FFFF;
	localparam logic [CC_W-1:0]        RST_CMP_CTRL = 5'h00;
	localparam logic [NS_W*CH_N-1:0]   RST_SEQ      = 6'h00;
	localparam logic [STAT_W-1:0]      RST_STAT     = 5'h00;

	// ****************************************
	// Timing: mclk cycles from a matching bus cycle to the forced event
	// ****************************************
	localparam int FORCED_STAGES = 2;

	typedef enum logic [NS_W-1:0] {
		dmt_seq_state1,
		dmt_seq_state2,
		dmt_seq_state3,
		dmt_seq_final
	} dmt_seq_type;

endpackage

// >>> rtl/dmt_cmp_if.sv
`timescale 1ns/10ps
interface dmt_cmp_if;
	logic [dmt_pkg::ADDR_W-1:0] bus_addr;
	logic [dmt_pkg::ADDR_W-1:0] limit_addr;
	logic                       hit_eq;
	logic                       hit_below;
	logic                       hit_above;

	modport ctl (output bus_addr, output limit_addr, input hit_eq, input hit_below, input hit_above);
	modport cmp (input bus_addr, input limit_addr, output hit_eq, output hit_below, output hit_above);
endinterface

// >>> rtl/dmt_comparator.sv
`timescale 1ns/10ps
module dmt_comparator (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Compare link
	dmt_cmp_if.cmp   link
);

	// ****************************************
	// Registered compare, one pipeline stage
	// ****************************************
	// Full-width compare so the limits reach both ends of the map
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.hit_eq    <= 1'b0;
			link.hit_below <= 1'b0;
			link.hit_above <= 1'b0;
		end else begin
			link.hit_eq    <= (link.bus_addr == link.limit_addr);
			link.hit_below <= (link.bus_addr < link.limit_addr);
			link.hit_above <= (link.bus_addr > link.limit_addr);
		end
	end

endmodule

// >>> tb/dmt_top_monitor.sv
`timescale 1ns/10ps
module dmt_top_monitor (
	// Clock and reset
	input wire logic                       mclk,
	input wire logic                       rst_b,
	// APB
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [dmt_pkg::APB_AW-1:0] paddr,
	input wire logic [dmt_pkg::APB_DW-1:0] pwdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// Watch and tagging
	input wire logic                       bus_valid,
	input wire logic                       bus_fetch,
	input wire logic                       tag_attach,
	input wire logic [dmt_pkg::CH_W-1:0]   tag_channel,
	// Breakpoint and interrupt
	input wire logic                       breakpoint_req,
	input wire logic                       irq
);
	logic [dmt_pkg::STAT_W-1:0] mask_reg;
	logic                       ctrl_wr;
	logic                       fetch_c;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	assign ctrl_wr = psel && penable && pwrite && paddr == dmt_pkg::OFS_CTRL;
	assign fetch_c = bus_valid && bus_fetch;

	// **********
	// Mask copy, so irq is judged from the bus alone
	// **********
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= '0;
		end else if (psel && penable && pwrite && paddr == dmt_pkg::OFS_MASK) begin
			mask_reg <= pwdata[dmt_pkg::STAT_W-1:0];
		end
	end

	sequence s_immediate_trigger_bit_end;
		ctrl_wr && pwdata[dmt_pkg::CTRL_IMMEDIATE_TRIGGER_BIT] && pwdata[dmt_pkg::CTRL_ARM] && pwdata[dmt_pkg::CTRL_END];
	endsequence
	sequence s_immediate_trigger_bit_begin;
		ctrl_wr && pwdata[dmt_pkg::CTRL_IMMEDIATE_TRIGGER_BIT] && !pwdata[dmt_pkg::CTRL_END];
	endsequence

	// **********
	// Checks
	// **********
	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("access phase not ready at once");
	a_slverr_access: assert property (pslverr |-> psel && penable)
		else $error("error flag outside access phase");
	a_immediate_trigger_bit_end_bkpt: assert property (s_immediate_trigger_bit_end |-> ##[1:2] breakpoint_req)
		else $error("end-aligned trigger gave no breakpoint");
	a_immediate_trigger_bit_begin_quiet: assert property (s_immediate_trigger_bit_begin |=> !breakpoint_req [*3])
		else $error("begin-aligned trigger gave a breakpoint");
	a_bkpt_single: assert property (breakpoint_req |=> !breakpoint_req [*2])
		else $error("breakpoint request not a single pulse");
	a_bkpt_irq: assert property (breakpoint_req && mask_reg[dmt_pkg::STAT_BKPT] |-> ##[0:2] irq)
		else $error("unmasked breakpoint event raised no interrupt");
	a_tag_from_fetch: assert property (tag_attach |-> $past(fetch_c, 3) || $past(fetch_c, 4))
		else $error("tag without a fetch");
	a_tag_chan_range: assert property (tag_attach |-> tag_channel <= 2'h2)
		else $error("tag on a missing channel");
endmodule

// >>> tb/dmt_cpu_model.sv
`timescale 1ns/10ps
module dmt_cpu_model (
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	// Processor bus
	output logic                            bus_valid,
	output logic [dmt_pkg::ADDR_W-1:0]      bus_addr,
	output logic                            bus_read,
	output logic                            bus_word,
	output logic                            bus_fetch,
	// Tag hits
	input  wire logic                       tag_attach,
	input  wire logic [dmt_pkg::CH_W-1:0]   tag_channel,
	output logic                            cpu_taghit,
	output logic [dmt_pkg::CH_W-1:0]        cpu_taghit_channel
);
	int                       exec_delay = 1;
	int                       cyc;
	int                       due_q[$];
	logic [dmt_pkg::CH_W-1:0] chan_q[$];

	initial begin
		bus_valid = 1'b0;
		bus_addr = '0;
		bus_read = 1'b0;
		bus_word = 1'b0;
		bus_fetch = 1'b0;
	end

	// **********
	// One bus cycle; released lines show the inverse so stale values never match
	// **********
	task automatic cycle(input logic [17:0] a, input logic rd, input logic wd, input logic ft);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_read <= rd;
		bus_word <= wd;
		bus_fetch <= ft;
		@(posedge mclk);
		bus_valid <= 1'b0;
		bus_addr <= ~a;
		bus_read <= ~rd;
		bus_word <= ~wd;
		bus_fetch <= ~ft;
		@(posedge mclk);
	endtask

	// **********
	// Tagged opcodes reach execution exec_delay cycles later
	// **********
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cyc = 0;
			due_q.delete();
			chan_q.delete();
			cpu_taghit <= 1'b0;
			cpu_taghit_channel <= 2'h0;
		end else begin
			cyc = cyc + 1;
			if (tag_attach === 1'b1) begin
				due_q.push_back(cyc + exec_delay);
				chan_q.push_back(tag_channel);
			end
			if (due_q.size() > 0 && due_q[0] <= cyc) begin
				cpu_taghit <= 1'b1;
				cpu_taghit_channel <= chan_q.pop_front();
				void'(due_q.pop_front());
			end else begin
				cpu_taghit <= 1'b0;
				cpu_taghit_channel <= ~cpu_taghit_channel;
			end
		end
	end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
bind dmt_top dmt_top_monitor dmt_top_monitor_i (
	.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.bus_valid(bus_valid), .bus_fetch(bus_fetch), .tag_attach(tag_attach),
	.tag_channel(tag_channel), .breakpoint_req(breakpoint_req), .irq(irq)
);
module testbench;
	logic                       mclk, rst_b, psel, penable, pwrite;
	logic [dmt_pkg::APB_AW-1:0] paddr;
	logic [dmt_pkg::APB_DW-1:0] pwdata, prdata;
	logic                       pready, pslverr;
	logic                       bus_valid, bus_read, bus_word, bus_fetch;
	logic [dmt_pkg::ADDR_W-1:0] bus_addr;
	logic                       tag_attach, cpu_taghit, breakpoint_req, irq;
	logic [dmt_pkg::CH_W-1:0]   tag_channel, cpu_taghit_channel;
	int                         err_total, n_tests, bkpt_n;

	dmt_top dmt_top_i (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_read(bus_read),
		.bus_word(bus_word), .bus_fetch(bus_fetch), .tag_attach(tag_attach),
		.tag_channel(tag_channel), .cpu_taghit(cpu_taghit),
		.cpu_taghit_channel(cpu_taghit_channel), .breakpoint_req(breakpoint_req), .irq(irq));
	dmt_cpu_model dmt_cpu_model_i (.mclk(mclk), .rst_b(rst_b), .bus_valid(bus_valid),
		.bus_addr(bus_addr), .bus_read(bus_read), .bus_word(bus_word), .bus_fetch(bus_fetch),
		.tag_attach(tag_attach), .tag_channel(tag_channel), .cpu_taghit(cpu_taghit),
		.cpu_taghit_channel(cpu_taghit_channel));

	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (breakpoint_req === 1'b1) bkpt_n++;
	end

	// **********
	// Shared tasks
	// **********
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			summarize();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
	endtask
	// Samples on the falling edge so the count never races the design
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 30) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 30) begin
			err_total++;
			summarize();
		end
		@(posedge mclk);
	endtask

	// **********
	// Scenarios
	// **********
	task automatic t_regs();
		logic [7:0]  offs[12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
			8'h1C, 8'h20, 8'h24, 8'h40, 8'h44, 8'h48};
		logic [31:0] q;
		logic        e;
		foreach (offs[i]) rd(offs[i], 32'h0);
		apb(1'b1, 8'h3C, 32'hFFFFFFFF, q, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 8'h3C, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		wr(8'h48, 32'hFFFFFFFF);
		rd(8'h48, 32'h3F);
		wr(8'h00, 32'h300);
		rd(8'h00, 32'h0);
	endtask
	task automatic setup_out(input logic [17:0] lo, input logic [17:0] hi);
		do_reset();
		wr(8'h10, {14'h0, lo});
		wr(8'h18, {14'h0, hi});
		wr(8'h14, 32'h1D);
		wr(8'h1C, 32'h01);
		wr(8'h40, 32'h05);
		wr(8'h08, 32'h1F);
		wr(8'h00, 32'h01);
	endtask
	task automatic t_outside();
		logic [31:0] q;
		logic        e;
		int          n;
		setup_out(18'h01000, 18'h02000);
		dmt_cpu_model_i.cycle(18'h01800, 1'b1, 1'b0, 1'b0);
		dmt_cpu_model_i.cycle(18'h02001, 1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge mclk);
		rd(8'h04, 32'h0);
		dmt_cpu_model_i.cycle(18'h00FFF, 1'b0, 1'b0, 1'b0);
		wait_irq(n);
		chk({31'h0, n >= 2 && n <= 3}, 32'h1);
		apb(1'b0, 8'h04, 32'h0, q, e);
		chk({31'h0, q[1:0] != 2'h0 && q[4:2] == 3'h0}, 32'h1);
		rd(8'h00, 32'h101);
		wr(8'h04, 32'h1F);
		rd(8'h04, 32'h0);
		chk({31'h0, irq}, 32'h0);
		setup_out(18'h00000, 18'h3FFFF);
		dmt_cpu_model_i.cycle(18'h00000, 1'b1, 1'b0, 1'b0);
		dmt_cpu_model_i.cycle(18'h3FFFF, 1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge mclk);
		rd(8'h04, 32'h0);
	endtask
	task automatic t_prio();
		logic [31:0] seq_t[2] = '{32'h31, 32'h21};
		logic [31:0] st_t[2] = '{32'h0C, 32'h01};
		logic [31:0] ct_t[2] = '{32'h301, 32'h101};
		for (int i = 0; i < 2; i++) begin
			do_reset();
			wr(8'h10, 32'h400);
			wr(8'h20, 32'h400);
			wr(8'h14, 32'h01);
			wr(8'h24, 32'h01);
			wr(8'h40, seq_t[i]);
			wr(8'h44, 32'h03);
			wr(8'h00, 32'h01);
			dmt_cpu_model_i.cycle(18'h00400, 1'b1, 1'b0, 1'b0);
			repeat (3) @(posedge mclk);
			rd(8'h04, st_t[i]);
			rd(8'h00, ct_t[i]);
		end
		dmt_cpu_model_i.cycle(18'h00400, 1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge mclk);
		rd(8'h04, 32'h09);
		rd(8'h00, 32'h301);
	endtask
	task automatic t_tag();
		int n;
		do_reset();
		dmt_cpu_model_i.exec_delay = 8;
		wr(8'h18, 32'h800);
		wr(8'h1C, 32'h03);
		wr(8'h40, 32'h08);
		wr(8'h08, 32'h02);
		wr(8'h00, 32'h01);
		dmt_cpu_model_i.cycle(18'h00800, 1'b1, 1'b0, 1'b1);
		repeat (2) @(posedge mclk);
		rd(8'h04, 32'h0);
		wait_irq(n);
		rd(8'h04, 32'h02);
		rd(8'h00, 32'h201);
		dmt_cpu_model_i.exec_delay = 1;
	endtask
	task automatic t_immediate_trigger_bit();
		logic [31:0] pre_t[3] = '{32'h0, 32'h0, 32'h1};
		logic [31:0] trg_t[3] = '{32'h3, 32'h7, 32'h2};
		logic [31:0] ct_t[3] = '{32'h301, 32'h4, 32'h301};
		logic [31:0] st_t[3] = '{32'h08, 32'h10, 32'h08};
		int          b0;
		for (int i = 0; i < 3; i++) begin
			do_reset();
			wr(8'h08, 32'h10);
			if (pre_t[i] != 32'h0) wr(8'h00, pre_t[i]);
			b0 = bkpt_n;
			wr(8'h00, trg_t[i]);
			repeat (2) @(posedge mclk);
			chk(bkpt_n - b0, i == 1);
			chk({31'h0, irq}, i == 1);
			rd(8'h04, st_t[i]);
			rd(8'h00, ct_t[i]);
		end
	endtask

	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		n_tests = 0;
		bkpt_n = 0;
		do_reset();
		t_regs();
		t_outside();
		t_prio();
		t_tag();
		t_immediate_trigger_bit();
		summarize();
	end
endmodule
